// *** bench/ptp_signature_and_timestamp_calc_test.sv ***
// Self-checking bench for the signature and time-stamp calculator
`timescale 1ns/10ps
`default_nettype none

module ptp_signature_and_timestamp_calc_test;
    import ptp_calc_pkg::*;
    typedef struct {int due; logic eg, upd, corr, pb; logic [1:0] sets; logic [127:0] sig; logic [79:0] ts;} exp_s;
    logic core_clk = 1'b0;
    logic rst_b, frame_valid, frame_egress, frame_channel, frame_event_msg, asym_add, asym_sub, out_correction_mode;
    logic out_valid, out_egress, sig_valid, ts_update, ts_is_correction, part_b_match;
    logic [255:0] ptp_header;
    addr_pair_s [3:0] stage_addr;
    logic [7:0][1:0] outer_eth_hits, inner_eth_hits, mpls_hits, ach_hits;
    flow_cfg_s [7:0] outer_eth_cfg, inner_eth_cfg, mpls_cfg, ach_cfg;
    logic [79:0] raw_timestamp, ts_out;
    logic [63:0] variable_latency, correction_in;
    logic [15:0][5:0] signature_byte_select;
    logic [1:0] signature_address_source, match_sets;
    logic [3:0] addr_use_dst;
    latency_cfg_s latency_cfg, shad;
    logic [127:0] signature;
    logic [15:0] stored_cnt;
    logic [207:0] last_entry, last_eg;
    logic [31:0] lfsr = 32'hf6d2_6908;
    exp_s q[$];
    exp_s r_e;
    int cyc = 0;
    int failures = 0;
    int compares = 0;
    int eg_cnt = 0;

    ptp_signature_and_timestamp_calc dut_u (.core_clk, .rst_b, .frame_valid, .frame_egress, .frame_channel,
        .frame_event_msg, .ptp_header, .stage_addr, .outer_eth_hits, .inner_eth_hits, .mpls_hits, .ach_hits,
        .raw_timestamp, .variable_latency, .correction_in, .outer_eth_cfg, .inner_eth_cfg, .mpls_cfg, .ach_cfg,
        .signature_byte_select, .signature_address_source, .addr_use_dst, .latency_cfg, .asym_add, .asym_sub,
        .out_correction_mode, .out_valid, .out_egress, .sig_valid, .signature, .ts_update, .ts_is_correction,
        .ts_out, .match_sets, .part_b_match);
    ts_store_sink sink_u (.core_clk, .rst_b, .out_valid, .sig_valid, .signature, .ts_out, .stored_cnt, .last_entry);

    always #10 core_clk = ~core_clk;

    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h8020_0003 : lfsr >> 1;
        end
        return lfsr;
    endfunction

    function automatic logic [1:0] stage_fn(flow_cfg_s [7:0] cfg, logic [7:0][1:0] hits, logic [1:0] prior, logic ch);
        logic [1:0] m;
        m = 2'b00;
        for (int f = 0; f < 8; f++) begin
            if (cfg[f].enable && cfg[f].chan_mask[ch]) m = m | (hits[f] & cfg[f].protocol_group_mask & prior);
        end
        return m;
    endfunction

    task automatic cmp_flag(logic got, logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_word(logic [127:0] got, logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic send_frame();
        exp_s e;
        logic [1:0] s1, s2, s3, s4, src;
        logic [63:0] a, c, asx;
        logic [7:0] byt;
        int sel;
        // Idle cycle lets the shadow reload
        repeat (2) @(posedge core_clk);
        #1;
        {frame_egress, frame_channel, asym_add, asym_sub, out_correction_mode} = 5'(rnd());
        frame_event_msg = (rnd() % 4) != 0;
        ptp_header = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        for (int i = 0; i < 4; i++) stage_addr[i] = {rnd(), rnd(), rnd(), rnd()};
        {outer_eth_hits, inner_eth_hits} = rnd();
        {mpls_hits, ach_hits} = rnd();
        for (int f = 0; f < 8; f++) begin
            a = {rnd(), rnd()};
            outer_eth_cfg[f] = {|a[1:0], a[5:2]};
            inner_eth_cfg[f] = {|a[7:6], a[11:8]};
            mpls_cfg[f] = {|a[13:12], a[17:14]};
            ach_cfg[f] = {|a[19:18], a[23:20]};
        end
        for (int b = 0; b < 16; b++) signature_byte_select[b] = 6'(rnd() % 37);
        {signature_address_source, addr_use_dst} = 6'(rnd());
        raw_timestamp = 80'({rnd(), rnd(), rnd()});
        variable_latency = {rnd(), rnd()};
        correction_in = {rnd(), rnd()};
        frame_valid = 1'b1;
        s1 = stage_fn(outer_eth_cfg, outer_eth_hits, 2'b11, frame_channel);
        s2 = stage_fn(inner_eth_cfg, inner_eth_hits, s1, frame_channel);
        s3 = stage_fn(mpls_cfg, mpls_hits, s2, frame_channel);
        s4 = stage_fn(ach_cfg, ach_hits, s3, frame_channel);
        e.pb = (s4 == 2'b00) && s1[1];
        e.sets = (s4 != 2'b00) ? s4 : s1;
        src = signature_address_source;
        a = addr_use_dst[src] ? stage_addr[src].dst : stage_addr[src].src;
        if (e.pb && src == 2'h1) a = '0;
        for (int b = 0; b < 16; b++) begin
            sel = int'(signature_byte_select[b]);
            byt = 8'h00;
            if (sel <= 23) byt = ptp_header[8*(31-sel)+:8];
            else if (sel == 24) byt = ptp_header[55:48];
            else if (sel == 25) byt = ptp_header[39:32];
            else if (sel == 26) byt = ptp_header[7:0];
            else if (sel >= 28 && sel <= 35) byt = a[8*(sel-28)+:8];
            e.sig[8*b+:8] = frame_egress ? byt : 8'h00;
        end
        asx = {{32{shad.link_asymmetry_value[31]}}, shad.link_asymmetry_value};
        c = correction_in + {16'h0000, shad.link_delay_ns, 16'h0000} + (asym_add ? asx : 64'h0) - (asym_sub ? asx : 64'h0);
        if (!frame_event_msg) e.ts = {16'h0000, correction_in};
        else if (out_correction_mode) e.ts = {{16{c[63]}}, c};
        else if (frame_egress) e.ts = raw_timestamp + {16'h0000, shad.fixed_latency} + {16'h0000, variable_latency};
        else e.ts = raw_timestamp - {16'h0000, shad.fixed_latency} - {16'h0000, variable_latency};
        {e.eg, e.upd, e.corr, e.due} = {frame_egress, frame_event_msg, out_correction_mode, cyc + 2};
        if (frame_egress) eg_cnt++;
        if (frame_egress) last_eg = {e.sig, e.ts};
        q.push_back(e);
        @(posedge core_clk);
        #1;
        frame_valid = 1'b0;
        latency_cfg = {rnd(), rnd(), rnd(), rnd()};
        shad = latency_cfg;
    endtask

    always @(posedge core_clk) cyc++;

    always @(negedge core_clk) begin
        if (rst_b === 1'b1 && out_valid === 1'b1) begin
            if (q.size() == 0) begin
                cmp_flag(out_valid, 1'b0);
            end else begin
                r_e = q.pop_front();
                cmp_word(128'(cyc), 128'(r_e.due));
                cmp_word(signature, r_e.sig);
                cmp_word(128'(ts_out), 128'(r_e.ts));
                cmp_flag(sig_valid, r_e.eg);
                cmp_flag(ts_update, r_e.upd);
                cmp_flag(ts_is_correction, r_e.corr);
                cmp_word(128'({match_sets, part_b_match}), 128'({r_e.sets, r_e.pb}));
                cmp_flag(out_egress, r_e.eg);
            end
        end
    end

    initial begin
        {rst_b, frame_valid, frame_egress, frame_channel, frame_event_msg} = '0;
        {asym_add, asym_sub, out_correction_mode, signature_address_source, addr_use_dst} = '0;
        {ptp_header, stage_addr, raw_timestamp, variable_latency, correction_in, signature_byte_select} = '0;
        {outer_eth_hits, inner_eth_hits, mpls_hits, ach_hits} = '0;
        {outer_eth_cfg, inner_eth_cfg, mpls_cfg, ach_cfg} = '0;
        latency_cfg = {rnd(), rnd(), rnd(), rnd()};
        shad = latency_cfg;
        last_eg = '0;
        repeat (4) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        cmp_flag(out_valid, 1'b0);
        cmp_word(128'(ts_out), 128'h0);
        repeat (400) send_frame();
        for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge core_clk);
        if (q.size() > 0) failures++;
        #1;
        cmp_word(128'(stored_cnt), 128'(eg_cnt));
        cmp_word(last_entry[207:80], last_eg[207:80]);
        cmp_word(128'(last_entry[79:0]), 128'(last_eg[79:0]));
        complete_run();
    end
endmodule // ptp_signature_and_timestamp_calc_test

`default_nettype wire

// *** bench/ts_store_sink.sv ***
// Downstream time-stamp storage model fed by the calculator
`timescale 1ns/10ps
`default_nettype none

module ts_store_sink (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         out_valid,
    input  wire logic         sig_valid,
    input  wire logic [127:0] signature,
    input  wire logic [79:0]  ts_out,
    output logic [15:0]       stored_cnt,
    output logic [207:0]      last_entry
);
    // Stores egress results only, signature with its time
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stored_cnt <= 16'h0000;
            last_entry <= '0;
        end else if (out_valid && sig_valid) begin
            stored_cnt <= stored_cnt + 16'h0001;
            last_entry <= {signature, ts_out};
        end
    end
endmodule // ts_store_sink

`default_nettype wire

// *** hw/ptp_calc_pkg.sv ***
// Shared constants and carriers for the signature and time-stamp calculator
package ptp_calc_pkg;

    // Signature layout
    localparam int SIG_BYTES      = 16;
    localparam int SEL_W          = 6;
    localparam int HDR_BYTES      = 32;
    localparam int ADDR_BYTES     = 8;

    // Byte select decoding
    localparam logic [5:0] SEL_HDR_LAST   = 6'h17;
    localparam int         HDR_BASE       = 31;
    localparam logic [5:0] SEL_HDR_B6     = 6'h18;
    localparam logic [5:0] SEL_HDR_B4     = 6'h19;
    localparam logic [5:0] SEL_HDR_B0     = 6'h1A;
    localparam logic [5:0] SEL_ADDR_FIRST = 6'h1C;
    localparam logic [5:0] SEL_ADDR_LAST  = 6'h23;
    localparam int         HDR_IDX_B6     = 6;
    localparam int         HDR_IDX_B4     = 4;
    localparam int         HDR_IDX_B0     = 0;

    // Address source codes
    localparam logic [1:0] ADDR_SRC_OUTER_ETHERNET_STAGE = 2'h0;
    localparam logic [1:0] ADDR_SRC_INNER_ETHERNET_STAGE = 2'h1;
    localparam logic [1:0] ADDR_SRC_IP1  = 2'h2;
    localparam logic [1:0] ADDR_SRC_IP2  = 2'h3;
    localparam int         ADDR_STAGES   = 4;

    // Flows, channels and protocol groups
    localparam int NUM_FLOWS = 8;
    localparam int NUM_CHAN  = 2;
    localparam int GRP_A     = 0;
    localparam int GRP_B     = 1;

    // Time formats and reset values
    localparam int          CF_FRAC_BITS   = 16;
    localparam logic [63:0] FIXED_LAT_RST  = 64'h0000_0000_0000_0000;
    localparam logic [31:0] LINK_DELAY_RST = 32'h0000_0000;
    localparam logic [31:0] ASYM_RST       = 32'h0000_0000;

    typedef enum logic {CALC_IDLE, CALC_BUSY} calc_state_e;

    typedef struct packed {
        logic       enable;
        logic [1:0] chan_mask;
        logic [1:0] protocol_group_mask;
    } flow_cfg_s;

    typedef struct packed {
        logic [63:0] src;
        logic [63:0] dst;
    } addr_pair_s;

    typedef struct packed {
        logic [63:0] fixed_latency;
        logic [31:0] link_delay_ns;
        logic [31:0] link_asymmetry_value;
    } latency_cfg_s;

endpackage : ptp_calc_pkg

// *** hw/ptp_signature_and_timestamp_calc.sv ***
// Frame signature builder, protocol-set chain and time-stamp corrector
`timescale 1ns/10ps
`default_nettype none

module ptp_signature_and_timestamp_calc
    import ptp_calc_pkg::*;
#(
    parameter int FLOWS = ptp_calc_pkg::NUM_FLOWS
) (
    input  wire logic                                    core_clk,
    input  wire logic                                    rst_b,
    input  wire logic                                    frame_valid,
    input  wire logic                                    frame_egress,
    input  wire logic                                    frame_channel,
    input  wire logic                                    frame_event_msg,
    input  wire logic [8*ptp_calc_pkg::HDR_BYTES-1:0]    ptp_header,
    input  wire ptp_calc_pkg::addr_pair_s [3:0]          stage_addr,
    input  wire logic [FLOWS-1:0][1:0]                   outer_eth_hits,
    input  wire logic [FLOWS-1:0][1:0]                   inner_eth_hits,
    input  wire logic [FLOWS-1:0][1:0]                   mpls_hits,
    input  wire logic [FLOWS-1:0][1:0]                   ach_hits,
    input  wire logic [79:0]                             raw_timestamp,
    input  wire logic [63:0]                             variable_latency,
    input  wire logic [63:0]                             correction_in,
    input  wire ptp_calc_pkg::flow_cfg_s [FLOWS-1:0]     outer_eth_cfg,
    input  wire ptp_calc_pkg::flow_cfg_s [FLOWS-1:0]     inner_eth_cfg,
    input  wire ptp_calc_pkg::flow_cfg_s [FLOWS-1:0]     mpls_cfg,
    input  wire ptp_calc_pkg::flow_cfg_s [FLOWS-1:0]     ach_cfg,
    input  wire logic [15:0][5:0]                        signature_byte_select,
    input  wire logic [1:0]                              signature_address_source,
    input  wire logic [3:0]                              addr_use_dst,
    input  wire ptp_calc_pkg::latency_cfg_s              latency_cfg,
    input  wire logic                                    asym_add,
    input  wire logic                                    asym_sub,
    input  wire logic                                    out_correction_mode,
    output logic                                         out_valid,
    output logic                                         out_egress,
    output logic                                         sig_valid,
    output logic [127:0]                                 signature,
    output logic                                         ts_update,
    output logic                                         ts_is_correction,
    output logic [79:0]                                  ts_out,
    output logic [1:0]                                   match_sets,
    output logic                                         part_b_match
);

    import ptp_calc_pkg::*;

    // Surviving protocol sets of one comparator stage
    function automatic logic [1:0] stage_sets(
        input flow_cfg_s [FLOWS-1:0] cfg,
        input logic [FLOWS-1:0][1:0] hits,
        input logic [1:0]            prior,
        input logic                  chan
    );
        stage_sets = 2'b00;
        for (int f = 0; f < FLOWS; f++) begin
            if (cfg[f].enable && cfg[f].chan_mask[chan]) begin
                stage_sets = stage_sets | (cfg[f].protocol_group_mask & prior & hits[f]);
            end
        end
    endfunction

    // One signature byte from its selector
    function automatic logic [7:0] pick_byte(
        input logic [5:0]   sel,
        input logic [255:0] hdr,
        input logic [63:0]  addr
    );
        logic [4:0] hidx;
        logic [5:0] aidx;
        hidx = 5'(HDR_BASE - int'(sel));
        aidx = sel - SEL_ADDR_FIRST;
        pick_byte = 8'h00;
        if (sel <= SEL_HDR_LAST) begin
            pick_byte = hdr[hidx*8 +: 8];
        end else if (sel == SEL_HDR_B6) begin
            pick_byte = hdr[HDR_IDX_B6*8 +: 8];
        end else if (sel == SEL_HDR_B4) begin
            pick_byte = hdr[HDR_IDX_B4*8 +: 8];
        end else if (sel == SEL_HDR_B0) begin
            pick_byte = hdr[HDR_IDX_B0*8 +: 8];
        end else if (sel >= SEL_ADDR_FIRST && sel <= SEL_ADDR_LAST) begin
            pick_byte = addr[aidx[2:0]*8 +: 8];
        end
    endfunction

    calc_state_e  state;
    latency_cfg_s shadow;
    logic [1:0]   next_outer_set;
    logic [1:0]   next_inner_set;
    logic [1:0]   next_mpls_set;
    logic [1:0]   s1_outer_set;
    logic [1:0]   s1_mpls_set;
    logic [FLOWS-1:0][1:0] s1_ach_hits;
    logic         s1_egress;
    logic         s1_chan;
    logic         s1_event;
    logic [255:0] s1_hdr;
    logic [63:0]  s1_addr;
    logic [79:0]  s1_raw;
    logic [63:0]  s1_var_lat;
    logic [63:0]  s1_cf_in;
    logic [1:0]   ach_set;
    logic         part_a;
    logic         part_b;
    logic [63:0]  sig_addr;
    logic [127:0] next_signature;
    logic [79:0]  active_ts;
    logic [63:0]  asym_ext;
    logic [63:0]  next_correction;

    // Protocol-set chain for the first three stages
    always_comb begin
        next_outer_set = stage_sets(outer_eth_cfg, outer_eth_hits, 2'b11, frame_channel);
        next_inner_set = stage_sets(inner_eth_cfg, inner_eth_hits, next_outer_set, frame_channel);
        next_mpls_set  = stage_sets(mpls_cfg, mpls_hits, next_inner_set, frame_channel);
    end

    // Pipeline occupancy
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= CALC_IDLE;
        end else begin
            case (state)
                CALC_IDLE: begin
                    state <= frame_valid ? CALC_BUSY : CALC_IDLE;
                end
                CALC_BUSY: begin
                    state <= frame_valid ? CALC_BUSY : CALC_IDLE;
                end
                default: begin
                    state <= CALC_IDLE;
                end
            endcase
        end
    end

    // Frame capture, first stage
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_outer_set <= 2'b00;
            s1_mpls_set  <= 2'b00;
            s1_ach_hits  <= '0;
            s1_egress    <= 1'b0;
            s1_chan      <= 1'b0;
            s1_event     <= 1'b0;
            s1_hdr       <= '0;
            s1_addr      <= 64'h0000_0000_0000_0000;
            s1_raw       <= '0;
            s1_var_lat   <= 64'h0000_0000_0000_0000;
            s1_cf_in     <= 64'h0000_0000_0000_0000;
        end else if (frame_valid) begin
            s1_outer_set <= next_outer_set;
            s1_mpls_set  <= next_mpls_set;
            s1_ach_hits  <= ach_hits;
            s1_egress    <= frame_egress;
            s1_chan      <= frame_channel;
            s1_event     <= frame_event_msg;
            s1_hdr       <= ptp_header;
            s1_addr      <= addr_use_dst[signature_address_source] ?
                            stage_addr[signature_address_source].dst : stage_addr[signature_address_source].src;
            s1_raw       <= raw_timestamp;
            s1_var_lat   <= variable_latency;
            s1_cf_in     <= correction_in;
        end
    end

    // ACH stage runs one cycle after MPLS
    always_comb begin
        ach_set = stage_sets(ach_cfg, s1_ach_hits, s1_mpls_set, s1_chan);
        part_a  = |ach_set;
        part_b  = !part_a && s1_outer_set[GRP_B];
        sig_addr = (part_b && signature_address_source == ADDR_SRC_INNER_ETHERNET_STAGE) ? 64'h0000_0000_0000_0000 : s1_addr;
    end

    // Signature assembly, byte 0 lowest
    generate
        for (genvar b = 0; b < SIG_BYTES; b++) begin : g_sig
            assign next_signature[b*8 +: 8] = pick_byte(signature_byte_select[b], s1_hdr, sig_addr);
        end
    endgenerate

    // Time correction arithmetic
    always_comb begin
        asym_ext = {{32{shadow.link_asymmetry_value[31]}}, shadow.link_asymmetry_value};
        if (s1_egress) begin
            active_ts = s1_raw + {16'h0000, shadow.fixed_latency} + {16'h0000, s1_var_lat};
        end else begin
            active_ts = s1_raw - {16'h0000, shadow.fixed_latency} - {16'h0000, s1_var_lat};
        end
        next_correction = s1_cf_in + {16'h0000, shadow.link_delay_ns, 16'h0000};
        if (asym_add) begin
            next_correction = next_correction + asym_ext;
        end
        if (asym_sub) begin
            next_correction = next_correction - asym_ext;
        end
    end

    // Shadow latency copies, reloaded only between frames
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shadow.fixed_latency        <= FIXED_LAT_RST;
            shadow.link_delay_ns        <= LINK_DELAY_RST;
            shadow.link_asymmetry_value <= ASYM_RST;
        end else if (state == CALC_IDLE && !frame_valid) begin
            shadow <= latency_cfg;
        end
    end

    // Result stage, signature and time together
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid        <= 1'b0;
            out_egress       <= 1'b0;
            sig_valid        <= 1'b0;
            signature        <= '0;
            ts_update        <= 1'b0;
            ts_is_correction <= 1'b0;
            ts_out           <= '0;
            match_sets       <= 2'b00;
            part_b_match     <= 1'b0;
        end else begin
            out_valid <= state == CALC_BUSY;
            if (state == CALC_BUSY) begin
                out_egress       <= s1_egress;
                sig_valid        <= s1_egress;
                signature        <= s1_egress ? next_signature : '0;
                ts_update        <= s1_event;
                ts_is_correction <= out_correction_mode;
                match_sets       <= part_a ? ach_set : s1_outer_set;
                part_b_match     <= part_b;
                if (!s1_event) begin
                    ts_out <= {16'h0000, s1_cf_in};
                end else if (out_correction_mode) begin
                    ts_out <= {{16{next_correction[63]}}, next_correction};
                end else begin
                    ts_out <= active_ts;
                end
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_accept;
        frame_valid;
    endsequence

    sequence s_present;
        ##2 out_valid;
    endsequence

    property p_present_latency;
        s_accept |-> s_present;
    endproperty
    a_present_latency: assert property (p_present_latency) else $error("result not presented two cycles after frame");

    property p_ingress_no_sig;
        out_valid && !out_egress |-> !sig_valid && signature == '0;
    endproperty
    a_ingress_no_sig: assert property (p_ingress_no_sig) else $error("signature produced for ingress frame");

    property p_shadow_hold;
        state == CALC_BUSY |-> $stable(shadow) ##1 $stable(shadow) || !out_valid;
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed during calculation");

    property p_non_event_pass;
        state == CALC_BUSY && !s1_event |=> ts_out == {16'h0000, $past(s1_cf_in)} && !ts_update;
    endproperty
    a_non_event_pass: assert property (p_non_event_pass) else $error("non-event message modified");

    property p_part_b_zero;
        state == CALC_BUSY && s1_egress && part_b && signature_address_source == ADDR_SRC_INNER_ETHERNET_STAGE &&
            signature_byte_select[0] >= SEL_ADDR_FIRST && signature_byte_select[0] <= SEL_ADDR_LAST |=>
            signature[7:0] == 8'h00;
    endproperty
    a_part_b_zero: assert property (p_part_b_zero) else $error("part B address bytes not zeroed");

    property p_set_chain;
        frame_valid |-> (next_inner_set & ~next_outer_set) == 2'b00 && (next_mpls_set & ~next_inner_set) == 2'b00
                        ##1 (ach_set & ~s1_mpls_set) == 2'b00;
    endproperty
    a_set_chain: assert property (p_set_chain) else $error("protocol sets mixed across stages");

    property p_hdr_byte;
        state == CALC_BUSY && s1_egress && signature_byte_select[0] <= SEL_HDR_LAST |=>
            signature[7:0] == $past(s1_hdr[(HDR_BASE - int'(signature_byte_select[0][4:0]))*8 +: 8]);
    endproperty
    a_hdr_byte: assert property (p_hdr_byte) else $error("signature byte 0 wrong header byte");

    property p_correction;
        state == CALC_BUSY && s1_event && out_correction_mode && asym_add && !asym_sub |=>
            ts_out[63:0] == $past(s1_cf_in) + {16'h0000, $past(shadow.link_delay_ns), 16'h0000} + $past(asym_ext);
    endproperty
    a_correction: assert property (p_correction) else $error("correction value wrong");

    property p_shadow_load;
        state == CALC_IDLE && !frame_valid |=> shadow == $past(latency_cfg);
    endproperty
    a_shadow_load: assert property (p_shadow_load) else $error("shadow not reloaded between frames");

    property p_egress_time;
        state == CALC_BUSY && s1_event && !out_correction_mode && s1_egress |=>
            ts_out == $past(s1_raw) + {16'h0000, $past(shadow.fixed_latency)} + {16'h0000, $past(s1_var_lat)};
    endproperty
    a_egress_time: assert property (p_egress_time) else $error("egress corrected time wrong");

    property p_ingress_time;
        state == CALC_BUSY && s1_event && !out_correction_mode && !s1_egress |=>
            ts_out == $past(s1_raw) - {16'h0000, $past(shadow.fixed_latency)} - {16'h0000, $past(s1_var_lat)};
    endproperty
    a_ingress_time: assert property (p_ingress_time) else $error("ingress corrected time wrong");

    property p_dir_flags;
        out_valid |-> sig_valid == out_egress;
    endproperty
    a_dir_flags: assert property (p_dir_flags) else $error("signature valid differs from direction");

endmodule // ptp_signature_and_timestamp_calc

`default_nettype wire
